// [core/pfr_map.svh]
`ifndef PFR_MAP_SVH
`define PFR_MAP_SVH
`define PFR_CF 0
`define PFR_PF 2
`define PFR_AF 4
`define PFR_ZF 6
`define PFR_SF 7
`define PFR_TF 8
`define PFR_IF 9
`define PFR_DF 10
`define PFR_OF 11
`define PFR_IO_PRIVILEGE_FIELD 13:12
`define PFR_LOW_BYTE 7:0
`define PFR_AUX_CARRY 4
`define PFR_MSB_BYTE 6'h07
`define PFR_MSB_WORD 6'h0f
`define PFR_MSB_DWORD 6'h1f
`define PFR_RESET_VAL 32'h0000_0002
`define PFR_FIXED_ONE 32'h0000_0002
`define PFR_WMASK 32'h0000_3fd5
`define PFR_STATUS_MASK 32'h0000_08d5
`define PFR_ACC_MASK 32'h0000_00d5
`define PFR_LOW_HALF 32'h0000_ffff
`define PFR_MASK_BYTE 32'h0000_00ff
`define PFR_CPL_TOP 2'h0
`endif

// [core/pfr_pkg.sv]
`default_nettype none
package pfr_pkg;
    typedef enum logic [4:0] {
        PFR_OP_NOP = 5'h00, PFR_OP_ADD = 5'h01, PFR_OP_ADC = 5'h02, PFR_OP_SUB = 5'h03,
        PFR_OP_SBB = 5'h04, PFR_OP_LOGIC = 5'h05, PFR_OP_STC = 5'h06, PFR_OP_CLC = 5'h07,
        PFR_OP_CMC = 5'h08, PFR_OP_STD = 5'h09, PFR_OP_CLD = 5'h0a, PFR_OP_LOAD_FLAGS_TO_ACC_INSN = 5'h0b,
        PFR_OP_STORE_ACC_TO_FLAGS_INSN = 5'h0c, PFR_OP_PUSH_FLAGS_INSN = 5'h0d, PFR_OP_POP_FLAGS_INSN = 5'h0e, PFR_OP_INTERRUPT_RETURN_INSN = 5'h0f,
        PFR_OP_TASK = 5'h10, PFR_OP_INT = 5'h11, PFR_OP_INT_TASK = 5'h12
    } pfr_op_t;
    typedef enum logic [1:0] {
        PFR_SZ_BYTE = 2'h0, PFR_SZ_WORD = 2'h1, PFR_SZ_DWORD = 2'h2
    } pfr_size_t;
    typedef enum logic [1:0] {
        PFR_ALU_ADD = 2'h0, PFR_ALU_SUB = 2'h1, PFR_ALU_PASS = 2'h2
    } pfr_alu_kind_t;
endpackage : pfr_pkg
`default_nettype wire

// [core/pfr_alu_if.sv]
`default_nettype none
interface pfr_alu_if;
    import pfr_pkg::*;
    logic [31:0] a;
    logic [31:0] b;
    pfr_alu_kind_t kind;
    logic cin;
    pfr_size_t size;
    logic [31:0] result;
    logic [31:0] status;
    modport core (output a, output b, output kind, output cin, output size,
        input result, input status);
    modport calc (input a, input b, input kind, input cin, input size,
        output result, output status);
endinterface : pfr_alu_if
`default_nettype wire

// [core/pfr_alu_flags.sv]
`include "pfr_map.svh"
`default_nettype none
module pfr_alu_flags
    import pfr_pkg::*;
(
    // Operand and flag carrier.
    pfr_alu_if.calc c
);
    logic [31:0] bb;
    logic [32:0] sum;
    logic [32:0] cv;
    logic [5:0] msb;
    logic [31:0] mask;
    logic sub;
    logic pass;

    assign sub = (c.kind == PFR_ALU_SUB);
    assign pass = (c.kind == PFR_ALU_PASS);
    assign bb = sub ? ~c.b : c.b;
    assign sum = {1'b0, c.a} + {1'b0, bb} + {32'h0, c.cin};
    assign cv = {sum[32], c.a ^ bb ^ sum[31:0]};

    always_comb begin
        unique case (c.size)
            PFR_SZ_BYTE: begin
                msb = `PFR_MSB_BYTE;
                mask = `PFR_MASK_BYTE;
            end
            PFR_SZ_WORD: begin
                msb = `PFR_MSB_WORD;
                mask = `PFR_LOW_HALF;
            end
            default: begin
                msb = `PFR_MSB_DWORD;
                mask = ~32'h0;
            end
        endcase
    end

    assign c.result = (pass ? c.b : sum[31:0]) & mask;

    always_comb begin
        c.status = 32'h0;
        c.status[`PFR_CF] = pass ? 1'b0 : (cv[msb + 6'h01] ^ sub);
        c.status[`PFR_PF] = ~^c.result[`PFR_LOW_BYTE];
        c.status[`PFR_AF] = pass ? 1'b0 : (cv[`PFR_AUX_CARRY] ^ sub);
        c.status[`PFR_ZF] = (c.result == 32'h0);
        c.status[`PFR_SF] = c.result[msb[4:0]];
        c.status[`PFR_OF] = pass ? 1'b0 : (cv[msb] ^ cv[msb + 6'h01]);
    end
endmodule : pfr_alu_flags
`default_nettype wire

// [core/pfr_cond_eval.sv]
`include "pfr_map.svh"
`default_nettype none
module pfr_cond_eval
(
    // Flag word and condition selector.
    input wire logic [31:0] flags,
    input wire logic [3:0] code,
    // Condition result.
    output logic taken
);
    logic base;
    logic lt;

    assign lt = flags[`PFR_SF] ^ flags[`PFR_OF];

    always_comb begin
        unique case (code[3:1])
            3'h0: base = flags[`PFR_OF];
            3'h1: base = flags[`PFR_CF];
            3'h2: base = flags[`PFR_ZF];
            3'h3: base = flags[`PFR_CF] | flags[`PFR_ZF];
            3'h4: base = flags[`PFR_SF];
            3'h5: base = flags[`PFR_PF];
            3'h6: base = lt;
            3'h7: base = lt | flags[`PFR_ZF];
        endcase
    end

    assign taken = base ^ code[0];
endmodule : pfr_cond_eval
`default_nettype wire

// [core/pfr_flags_top.sv]
`include "pfr_map.svh"
`default_nettype none
module pfr_flags_top
    import pfr_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    input wire logic init,
    // Retiring operation.
    input wire logic op_retire,
    input wire pfr_op_t op_code,
    input wire pfr_size_t op_size,
    input wire logic op_wide,
    input wire logic [31:0] op_a,
    input wire logic [31:0] op_b,
    input wire logic [31:0] op_load_data,
    input wire logic [1:0] current_privilege_level,
    // Queries.
    input wire logic [3:0] cond_code,
    input wire logic irq_req,
    input wire logic io_req,
    // Flag word and datapath results.
    output logic [31:0] processor_flags_word,
    output logic [31:0] alu_result,
    output logic [7:0] acc_flags_byte,
    output logic acc_flags_valid,
    output logic [31:0] stack_push_data,
    output logic stack_push_valid,
    output logic [31:0] task_save_data,
    output logic task_save_valid,
    // Control outputs.
    output logic cond_true,
    output logic string_step_down,
    output logic irq_accept,
    output logic single_step,
    output logic io_permit
);
    ////////////////////////////////////////////////////////////////////////////////
    logic [31:0] flags_r;
    logic [31:0] flags_nxt;
    logic [31:0] result_r;
    logic [31:0] result_nxt;
    logic [7:0] acc_r;
    logic [7:0] acc_nxt;
    logic acc_v_r;
    logic acc_v_nxt;
    logic [31:0] push_r;
    logic [31:0] push_nxt;
    logic push_v_r;
    logic push_v_nxt;
    logic [31:0] save_r;
    logic [31:0] save_nxt;
    logic save_v_r;
    logic save_v_nxt;
    logic cond_r;
    logic cond_nxt;
    logic irq_r;
    logic irq_nxt;
    logic io_r;
    logic io_nxt;
    logic cond_now;
    logic io_ok;

    pfr_alu_if alu ();

    ////////////////////////////////////////////////////////////////////////////////
    // Arithmetic operand steering.
    assign alu.a = op_a;
    assign alu.b = op_b;
    assign alu.size = op_size;

    always_comb begin
        unique case (op_code)
            PFR_OP_ADD, PFR_OP_ADC: alu.kind = PFR_ALU_ADD;
            PFR_OP_SUB, PFR_OP_SBB: alu.kind = PFR_ALU_SUB;
            default: alu.kind = PFR_ALU_PASS;
        endcase
    end

    always_comb begin
        unique case (op_code)
            PFR_OP_ADC: alu.cin = flags_r[`PFR_CF];
            PFR_OP_SBB: alu.cin = ~flags_r[`PFR_CF];
            PFR_OP_SUB: alu.cin = 1'b1;
            default: alu.cin = 1'b0;
        endcase
    end

    pfr_alu_flags u_alu (
        .c(alu.calc)
    );

    pfr_cond_eval u_cond (
        .flags(flags_r),
        .code(cond_code),
        .taken(cond_now)
    );

    assign io_ok = current_privilege_level <= flags_r[`PFR_IO_PRIVILEGE_FIELD];

    ////////////////////////////////////////////////////////////////////////////////
    // Flag update and group transfers.
    always_comb begin
        logic [31:0] pop_mask;
        pop_mask = op_wide ? `PFR_WMASK : (`PFR_WMASK & `PFR_LOW_HALF);
        if (current_privilege_level != `PFR_CPL_TOP) begin
            pop_mask[`PFR_IO_PRIVILEGE_FIELD] = 2'h0;
        end
        if (!io_ok) begin
            pop_mask[`PFR_IF] = 1'b0;
        end
        flags_nxt = flags_r;
        result_nxt = result_r;
        acc_nxt = acc_r;
        acc_v_nxt = 1'b0;
        push_nxt = push_r;
        push_v_nxt = 1'b0;
        save_nxt = save_r;
        save_v_nxt = 1'b0;
        if (op_retire) begin
            unique case (op_code)
                PFR_OP_ADD, PFR_OP_ADC, PFR_OP_SUB, PFR_OP_SBB, PFR_OP_LOGIC: begin
                    flags_nxt = (flags_r & ~`PFR_STATUS_MASK)
                        | (alu.status & `PFR_STATUS_MASK);
                    result_nxt = alu.result;
                end
                PFR_OP_STC: flags_nxt[`PFR_CF] = 1'b1;
                PFR_OP_CLC: flags_nxt[`PFR_CF] = 1'b0;
                PFR_OP_CMC: flags_nxt[`PFR_CF] = ~flags_r[`PFR_CF];
                PFR_OP_STD: flags_nxt[`PFR_DF] = 1'b1;
                PFR_OP_CLD: flags_nxt[`PFR_DF] = 1'b0;
                PFR_OP_LOAD_FLAGS_TO_ACC_INSN: begin
                    acc_nxt = flags_r[`PFR_LOW_BYTE];
                    acc_v_nxt = 1'b1;
                end
                PFR_OP_STORE_ACC_TO_FLAGS_INSN: begin
                    flags_nxt = (flags_r & ~`PFR_ACC_MASK)
                        | ({24'h0, op_load_data[15:8]} & `PFR_ACC_MASK);
                end
                PFR_OP_PUSH_FLAGS_INSN: begin
                    push_nxt = op_wide ? flags_r : (flags_r & `PFR_LOW_HALF);
                    push_v_nxt = 1'b1;
                end
                PFR_OP_POP_FLAGS_INSN, PFR_OP_INTERRUPT_RETURN_INSN: begin
                    flags_nxt = (flags_r & ~pop_mask) | (op_load_data & pop_mask);
                end
                PFR_OP_TASK, PFR_OP_INT_TASK: begin
                    save_nxt = flags_r;
                    save_v_nxt = 1'b1;
                    flags_nxt = (op_load_data & `PFR_WMASK) | `PFR_FIXED_ONE;
                end
                PFR_OP_INT: begin
                    push_nxt = flags_r;
                    push_v_nxt = 1'b1;
                end
                default: begin
                end
            endcase
        end
        if (init) begin
            flags_nxt = `PFR_RESET_VAL;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registered queries.
    always_comb begin
        cond_nxt = cond_now;
        irq_nxt = irq_req & flags_r[`PFR_IF];
        io_nxt = io_req & io_ok;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flags_r <= `PFR_RESET_VAL;
            result_r <= 32'h0;
            acc_r <= 8'h0;
            acc_v_r <= 1'b0;
            push_r <= 32'h0;
            push_v_r <= 1'b0;
            save_r <= 32'h0;
            save_v_r <= 1'b0;
            cond_r <= 1'b0;
            irq_r <= 1'b0;
            io_r <= 1'b0;
        end else begin
            flags_r <= (flags_nxt & `PFR_WMASK) | `PFR_FIXED_ONE;
            result_r <= result_nxt;
            acc_r <= acc_nxt;
            acc_v_r <= acc_v_nxt;
            push_r <= push_nxt;
            push_v_r <= push_v_nxt;
            save_r <= save_nxt;
            save_v_r <= save_v_nxt;
            cond_r <= cond_nxt;
            irq_r <= irq_nxt;
            io_r <= io_nxt;
        end
    end

    assign processor_flags_word = flags_r;
    assign alu_result = result_r;
    assign acc_flags_byte = acc_r;
    assign acc_flags_valid = acc_v_r;
    assign stack_push_data = push_r;
    assign stack_push_valid = push_v_r;
    assign task_save_data = save_r;
    assign task_save_valid = save_v_r;
    assign cond_true = cond_r;
    assign string_step_down = flags_r[`PFR_DF];
    assign irq_accept = irq_r;
    assign single_step = flags_r[`PFR_TF];
    assign io_permit = io_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.
    chk_init_value: assert property (@(posedge clk) disable iff (rst)
        init |=> processor_flags_word == `PFR_RESET_VAL)
        else $error("Init did not load the reset flag value.");

    chk_carry_set: assert property (@(posedge clk) disable iff (rst)
        op_retire && op_code == PFR_OP_STC && !init |=> processor_flags_word[`PFR_CF])
        else $error("Set-carry did not set the carry flag.");

    chk_carry_flip: assert property (@(posedge clk) disable iff (rst)
        op_retire && op_code == PFR_OP_CMC && !init
        |=> processor_flags_word[`PFR_CF] != $past(processor_flags_word[`PFR_CF]))
        else $error("Complement-carry did not invert the carry flag.");

    chk_dir_step: assert property (@(posedge clk) disable iff (rst)
        op_retire && op_code == PFR_OP_STD && !init |=> string_step_down)
        else $error("Direction set did not select downward stepping.");

    chk_dir_clear: assert property (@(posedge clk) disable iff (rst)
        op_retire && op_code == PFR_OP_CLD && !init |=> !string_step_down)
        else $error("Direction clear did not select upward stepping.");

    chk_carry_clear: assert property (@(posedge clk) disable iff (rst)
        op_retire && op_code == PFR_OP_CLC && !init |=> !processor_flags_word[`PFR_CF])
        else $error("Clear-carry did not clear the carry flag.");

    chk_sign_flag: assert property (@(posedge clk) disable iff (rst)
        op_retire && !init && op_code inside {PFR_OP_ADD, PFR_OP_SUB, PFR_OP_LOGIC}
        && op_size == PFR_SZ_DWORD
        |=> processor_flags_word[`PFR_SF] == alu_result[31])
        else $error("Sign flag disagrees with the result.");

    chk_irq_gate: assert property (@(posedge clk) disable iff (rst)
        irq_accept |-> $past(irq_req) && $past(processor_flags_word[`PFR_IF]))
        else $error("Interrupt accepted while interrupts were disabled.");

    chk_io_privilege_field_guard: assert property (@(posedge clk) disable iff (rst)
        op_retire && !init && current_privilege_level != `PFR_CPL_TOP
        && (op_code == PFR_OP_POP_FLAGS_INSN || op_code == PFR_OP_INTERRUPT_RETURN_INSN)
        |=> $stable(processor_flags_word[`PFR_IO_PRIVILEGE_FIELD]))
        else $error("Privilege field changed below top privilege.");

    chk_idle_hold: assert property (@(posedge clk) disable iff (rst)
        !op_retire && !init |=> $stable(processor_flags_word))
        else $error("Flags changed without a retiring operation.");

    chk_zero_flag: assert property (@(posedge clk) disable iff (rst)
        op_retire && !init && op_code inside {PFR_OP_ADD, PFR_OP_SUB, PFR_OP_LOGIC}
        |=> processor_flags_word[`PFR_ZF] == (alu_result == 32'h0))
        else $error("Zero flag disagrees with the result.");

    chk_parity_flag: assert property (@(posedge clk) disable iff (rst)
        op_retire && !init && op_code inside {PFR_OP_ADD, PFR_OP_SUB, PFR_OP_LOGIC}
        |=> processor_flags_word[`PFR_PF] == ~^alu_result[`PFR_LOW_BYTE])
        else $error("Parity flag disagrees with the result.");

    chk_task_save: assert property (@(posedge clk) disable iff (rst)
        op_retire && op_code == PFR_OP_TASK
        |=> task_save_valid && task_save_data == $past(processor_flags_word))
        else $error("Task switch did not save the outgoing flags.");

    chk_io_permit: assert property (@(posedge clk) disable iff (rst)
        io_permit |-> $past(io_req)
        && $past(current_privilege_level) <= $past(processor_flags_word[`PFR_IO_PRIVILEGE_FIELD]))
        else $error("I/O permitted above the privilege field.");

    chk_int_push: assert property (@(posedge clk) disable iff (rst)
        op_retire && op_code == PFR_OP_INT
        |=> stack_push_valid && stack_push_data == $past(processor_flags_word))
        else $error("Handler entry did not push the flags.");
endmodule : pfr_flags_top
`default_nettype wire

// [verif/pfr_core_model.sv]
`default_nettype none
module pfr_core_model
    import pfr_pkg::*;
(
    // Clock.
    input wire logic clk,
    // Operation port.
    output var logic op_retire,
    output var pfr_op_t op_code,
    output var pfr_size_t op_size,
    output var logic op_wide,
    output var logic [31:0] op_a,
    output var logic [31:0] op_b,
    output var logic [31:0] op_load_data,
    // Pushed flag images.
    input wire logic [31:0] stack_push_data,
    input wire logic stack_push_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] saved_image = 32'h0000_0002;
    initial begin
        op_retire = 1'b0;
        op_code = PFR_OP_NOP;
        op_size = PFR_SZ_DWORD;
        op_wide = 1'b1;
        op_a = 32'h0;
        op_b = 32'h0;
        op_load_data = 32'h0;
    end
    // Keeps only the defined flag bits of the last pushed image.
    always @(posedge clk) begin
        if (stack_push_valid) begin
            saved_image <= (stack_push_data & 32'h0000_3fd5) | 32'h0000_0002;
        end
    end
    // Presents one retiring operation for one edge; op_retire stays high after it returns.
    task automatic issue(input pfr_op_t c, input pfr_size_t s, input logic w,
            input logic [31:0] a, input logic [31:0] b, input logic [31:0] ld);
        op_retire = 1'b1;
        op_code = c;
        op_size = s;
        op_wide = w;
        op_a = a;
        op_b = b;
        op_load_data = ld;
        @(negedge clk);
    endtask : issue
    task automatic quiet();
        op_retire = 1'b0;
        @(negedge clk);
    endtask : quiet
    // Pops the saved image back.
    task automatic restore();
        issue(PFR_OP_POP_FLAGS_INSN, PFR_SZ_DWORD, 1'b1, 32'h0, 32'h0, saved_image);
    endtask : restore
endmodule : pfr_core_model
`default_nettype wire

// [verif/test_processor_flags_register.sv]
`default_nettype none
module test_processor_flags_register
    import pfr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic init = 1'b0;
    logic [1:0] current_privilege_level = 2'h0;
    logic [3:0] cond_code = 4'h0;
    logic irq_req = 1'b0;
    logic io_req = 1'b0;
    logic op_retire, op_wide, acc_flags_valid, stack_push_valid, task_save_valid;
    logic cond_true, string_step_down, irq_accept, single_step, io_permit;
    pfr_op_t op_code;
    pfr_size_t op_size;
    logic [31:0] op_a, op_b, op_load_data, processor_flags_word, alu_result;
    logic [31:0] stack_push_data, task_save_data;
    logic [7:0] acc_flags_byte;
    int bad_count = 0;
    int num_checks = 0;
    always #2 clk = ~clk;
    pfr_core_model pm (.clk(clk), .op_retire(op_retire), .op_code(op_code),
        .op_size(op_size), .op_wide(op_wide), .op_a(op_a), .op_b(op_b),
        .op_load_data(op_load_data), .stack_push_data(stack_push_data),
        .stack_push_valid(stack_push_valid));
    pfr_flags_top dut (.clk(clk), .rst(rst), .init(init), .op_retire(op_retire),
        .op_code(op_code), .op_size(op_size), .op_wide(op_wide), .op_a(op_a), .op_b(op_b),
        .op_load_data(op_load_data), .current_privilege_level(current_privilege_level),
        .cond_code(cond_code), .irq_req(irq_req), .io_req(io_req),
        .processor_flags_word(processor_flags_word), .alu_result(alu_result),
        .acc_flags_byte(acc_flags_byte), .acc_flags_valid(acc_flags_valid),
        .stack_push_data(stack_push_data), .stack_push_valid(stack_push_valid),
        .task_save_data(task_save_data), .task_save_valid(task_save_valid),
        .cond_true(cond_true), .string_step_down(string_step_down),
        .irq_accept(irq_accept), .single_step(single_step), .io_permit(io_permit));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict
    task automatic op(input pfr_op_t c, input logic w, input logic [31:0] ld,
            input logic [31:0] ef);
        pm.issue(c, PFR_SZ_DWORD, w, 32'h0, 32'h0, ld);
        check(processor_flags_word, ef);
    endtask : op
    task automatic arith(input pfr_op_t c, input pfr_size_t s, input logic [31:0] a,
            input logic [31:0] b, input logic [31:0] er, input logic [31:0] ef);
        pm.issue(c, s, 1'b1, a, b, 32'h0);
        check(processor_flags_word, ef);
        check(alu_result, er);
    endtask : arith
    // Condition expected from the flag word.
    function automatic logic cexp(input logic [31:0] f, input logic [3:0] c);
        logic r;
        case (c[3:1])
            3'h0: r = f[11];
            3'h1: r = f[0];
            3'h2: r = f[6];
            3'h3: r = f[0] | f[6];
            3'h4: r = f[7];
            3'h5: r = f[2];
            3'h6: r = f[7] ^ f[11];
            default: r = f[6] | (f[7] ^ f[11]);
        endcase
        return r ^ c[0];
    endfunction : cexp
    task automatic q(input logic [3:0] cc, input logic irq, input logic io, input logic [1:0] lvl,
            input logic ec, input logic ei, input logic eo);
        cond_code = cc;
        irq_req = irq;
        io_req = io;
        current_privilege_level = lvl;
        @(negedge clk);
        check(cond_true, ec);
        check(irq_accept, ei);
        check(io_permit, eo);
    endtask : q
    task automatic sweep(input logic [31:0] f);
        for (int i = 0; i < 16; i++) begin
            q(4'(i), 1'b0, 1'b0, current_privilege_level, cexp(f, 4'(i)), 1'b0, 1'b0);
        end
    endtask : sweep
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #40000;
        bad_count++;
        give_verdict();
    end
    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        check(processor_flags_word, 32'h0000_0002);
        arith(PFR_OP_ADD, PFR_SZ_DWORD, 32'h1, 32'hffff_ffff, 32'h0, 32'h57);
        arith(PFR_OP_ADD, PFR_SZ_BYTE, 32'h7f, 32'h1, 32'h80, 32'h892);
        arith(PFR_OP_SUB, PFR_SZ_DWORD, 32'h0, 32'h1, 32'hffff_ffff, 32'h97);
        arith(PFR_OP_ADC, PFR_SZ_DWORD, 32'h0, 32'h0, 32'h1, 32'h2);
        op(PFR_OP_STC, 1'b1, 32'h0, 32'h3);
        arith(PFR_OP_SBB, PFR_SZ_WORD, 32'h5, 32'h2, 32'h2, 32'h2);
        arith(PFR_OP_ADD, PFR_SZ_WORD, 32'h8000, 32'h8000, 32'h0, 32'h847);
        op(PFR_OP_CMC, 1'b1, 32'h0, 32'h846);
        op(PFR_OP_CMC, 1'b1, 32'h0, 32'h847);
        op(PFR_OP_CLC, 1'b1, 32'h0, 32'h846);
        arith(PFR_OP_LOGIC, PFR_SZ_DWORD, 32'h0, 32'h8000_0000, 32'h8000_0000, 32'h86);
        arith(PFR_OP_SUB, PFR_SZ_BYTE, 32'h10, 32'h1, 32'h0f, 32'h16);
        op(PFR_OP_STD, 1'b1, 32'h0, 32'h416);
        check(string_step_down, 1'b1);
        op(PFR_OP_CLD, 1'b1, 32'h0, 32'h16);
        check(string_step_down, 1'b0);
        op(PFR_OP_STORE_ACC_TO_FLAGS_INSN, 1'b1, 32'h0000_ff00, 32'hd7);
        op(PFR_OP_LOAD_FLAGS_TO_ACC_INSN, 1'b1, 32'h0, 32'hd7);
        check({acc_flags_valid, acc_flags_byte}, 32'h1d7);
        op(PFR_OP_PUSH_FLAGS_INSN, 1'b1, 32'h0, 32'hd7);
        check({stack_push_valid, stack_push_data}, 33'h1_0000_00d7);
        op(PFR_OP_POP_FLAGS_INSN, 1'b1, 32'hffff_ffff, 32'h3fd7);
        check(single_step, 1'b1);
        pm.quiet();
        sweep(32'h3fd7);
        q(4'h0, 1'b1, 1'b1, 2'h3, 1'b1, 1'b1, 1'b1);
        op(PFR_OP_POP_FLAGS_INSN, 1'b1, 32'h0, 32'h3002);
        check(single_step, 1'b0);
        pm.quiet();
        q(4'h0, 1'b1, 1'b1, 2'h3, 1'b0, 1'b0, 1'b1);
        sweep(32'h3002);
        current_privilege_level = 2'h0;
        op(PFR_OP_POP_FLAGS_INSN, 1'b1, 32'h1200, 32'h1202);
        pm.quiet();
        q(4'h0, 1'b1, 1'b1, 2'h2, 1'b0, 1'b1, 1'b0);
        q(4'h0, 1'b1, 1'b1, 2'h1, 1'b0, 1'b1, 1'b1);
        check(processor_flags_word, 32'h1202);
        op(PFR_OP_INTERRUPT_RETURN_INSN, 1'b1, 32'h2000, 32'h1002);
        current_privilege_level = 2'h0;
        op(PFR_OP_POP_FLAGS_INSN, 1'b0, 32'hffff_00d5, 32'hd7);
        op(PFR_OP_INT, 1'b1, 32'h0, 32'hd7);
        check({stack_push_valid, stack_push_data}, 33'h1_0000_00d7);
        op(PFR_OP_TASK, 1'b1, 32'hffff_ffff, 32'h3fd7);
        check({task_save_valid, task_save_data}, 33'h1_0000_00d7);
        op(PFR_OP_INT_TASK, 1'b1, 32'h0, 32'h2);
        check({task_save_valid, task_save_data}, 33'h1_0000_3fd7);
        pm.restore();
        check(processor_flags_word, 32'hd7);
        init = 1'b1;
        op(PFR_OP_STC, 1'b1, 32'h0, 32'h2);
        init = 1'b0;
        pm.quiet();
        rst = 1'b1;
        @(negedge clk);
        check(processor_flags_word, 32'h2);
        check(alu_result, 32'h0);
        rst = 1'b0;
        arith(PFR_OP_ADD, PFR_SZ_BYTE, 32'hff, 32'h1, 32'h0, 32'h57);
        pm.quiet();
        give_verdict();
    end
endmodule : test_processor_flags_register
`default_nettype wire
